// File: rtl/rmtr_ctrl.sv
`timescale 1ns/1ps
// Function
// [RL1] duty query 0x23 recognised, answered
// [RL2] duty answer: type 0x02, 8 bytes, success
// [RL3] byte 7: used allowance, 0 to 100
// [RL4] slot count and slot length reported
// [RL5] seconds left and load after slot
// [RL6] transmit-only command 0x40, mode in byte two
// [RL7] mode 0 normal, 1 idle, 2 auto sleep
// [RL8] normal mode stays receiving unless busy
// [RL9] transmit-only: idle, receiver off after send
// [RL10] idle request: send, complete event, idle again
// [RL11] auto sleep: indefinite sleep after each send
// [RL12] sleep held until next host command
// [RL13] no repeating while transmit-only active
// [RL14] qualifying telegram retransmitted, then receive
// [RL15] one-level: only originals, after random delay
// [RL16] two-level: originals or once repeated
// [RL17] repeat counter incremented on retransmit
// [RL18] selective: only filter-matching telegrams repeated
// [RL19] repeater command 0x09, three bytes
// [RL20] select byte: off, all, selective
// [RL21] depth byte: none, one, two level
// [RL22] repeater setting kept in non-volatile store
// [RL23] ten slots of 360 seconds tracked
// [RL24] exhausted budget refuses sends, lock error
// [RL25] out-of-range argument: error, no change
// [RL26] accepted configuration answered with success
module rmtr_ctrl #(
    parameter int SEC_CYCLES = rmtr_pkg::CLK_HZ  // cycles per second
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        cmdValid,      // parsed host packet pulse
    input  wire logic [7:0]  cmdType,
    input  wire logic [15:0] cmdLen,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [7:0]  cmdArg1,       // data offset 7
    input  wire logic [7:0]  cmdArg2,       // data offset 8
    input  wire logic        txReq,         // host transmit request pulse
    input  wire logic [7:0]  budgetUsedPct, // from duty accumulator
    input  wire logic [7:0]  budgetNextPct,
    input  wire logic        budgetEmpty,
    input  wire logic        radioDone,     // radio finished sending
    input  wire logic        telValid,      // received valid telegram
    input  wire logic [3:0]  telRepCount,
    input  wire logic        telFilterHit,
    input  wire logic [7:0]  nvRepSelect,   // stored repeater setting
    input  wire logic [7:0]  nvRepDepth,
    output logic             rspValid,
    output logic [7:0]       rspType,
    output logic [15:0]      rspLen,
    output logic [7:0]       rspReturn,
    output logic [7:0]       rspUsedPct,
    output logic [7:0]       rspSlots,
    output logic [15:0]      rspSlotPeriod,
    output logic [15:0]      rspSlotLeft,
    output logic [7:0]       rspNextPct,
    output logic             radioSend,     // start send pulse
    output logic             sendIsRepeat,
    output logic [3:0]       repCountOut,
    output logic             receiverOn,
    output logic             sleeping,
    output logic [15:0]      sleepDuration,
    output logic             transmitCompleteEvent,
    output logic             slotTick,      // new slot begins
    output logic             nvWrite,
    output logic [7:0]       nvRepSelectOut,
    output logic [7:0]       nvRepDepthOut
);
    rmtr_pkg::rmtr_state_type stateFf;       // radio control state
    logic [7:0]  modeFf;                     // operating mode
    logic [7:0]  repSelFf;                   // repeat select
    logic [7:0]  repDepthFf;                 // repeat depth
    logic        nvLoadedFf;                 // store copied once
    logic [31:0] secCntFf;                   // cycle prescaler
    logic [15:0] slotLeftFf;                 // seconds left in slot
    logic [15:0] lfsrFf;                     // random delay source
    logic [7:0]  delayFf;                    // repeat delay count
    logic [3:0]  repCntFf;                   // pending repeat count
    logic        sendingRepeatFf;            // current send is repeat
    logic        isCmd;
    logic        repQualify;

    // argument range check, used for both arguments cmdArg1 and cmdArg2
    function automatic logic argOk(input logic [7:0] a);
        argOk = (a <= rmtr_pkg::ARG_MAX);
    endfunction

    assign isCmd = cmdValid && (cmdType == rmtr_pkg::PKT_COMMAND);

    // telegram qualifies for repeating
    always_comb begin
        repQualify = 1'b0;
        if (telValid && (modeFf == rmtr_pkg::MODE_RXTX)) begin  // RL13
            if ((repSelFf == rmtr_pkg::REP_ALL) ||
                ((repSelFf == rmtr_pkg::REP_SELECT) && telFilterHit)) begin  // RL18
                if (repDepthFf == rmtr_pkg::DEPTH_ONE)
                    repQualify = (telRepCount == 4'h0);  // RL15
                else if (repDepthFf == rmtr_pkg::DEPTH_TWO)
                    repQualify = (telRepCount <= rmtr_pkg::REP_CNT_ONE);  // RL16
            end
        end
    end

    // one-second prescaler and slot countdown
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            secCntFf   <= 32'h0;
            slotLeftFf <= rmtr_pkg::SLOT_SECONDS;
            slotTick   <= 1'b0;
        end else begin
            slotTick <= 1'b0;
            if (secCntFf == 32'(SEC_CYCLES - 1)) begin
                secCntFf <= 32'h0;
                if (slotLeftFf == 16'h1) begin  // RL23
                    slotLeftFf <= rmtr_pkg::SLOT_SECONDS;
                    slotTick   <= 1'b1;
                end else begin
                    slotLeftFf <= slotLeftFf - 16'h1;
                end
            end else begin
                secCntFf <= secCntFf + 32'h1;
            end
        end
    end

    // configuration registers and non-volatile copy
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            modeFf         <= rmtr_pkg::MODE_RXTX;
            repSelFf       <= rmtr_pkg::REP_OFF;
            repDepthFf     <= rmtr_pkg::REP_OFF;
            nvLoadedFf     <= 1'b0;
            nvWrite        <= 1'b0;
            nvRepSelectOut <= rmtr_pkg::REP_OFF;
            nvRepDepthOut  <= rmtr_pkg::REP_OFF;
        end else begin
            nvWrite <= 1'b0;
            if (!nvLoadedFf) begin
                // restore stored setting after reset release
                nvLoadedFf <= 1'b1;
                repSelFf   <= nvRepSelect;  // RL22
                repDepthFf <= nvRepDepth;   // RL22
            end else if (isCmd && (cmdCode == rmtr_pkg::CMD_TXONLY) &&
                         (cmdLen == rmtr_pkg::LEN_TXONLY) && argOk(cmdArg1)) begin
                modeFf <= cmdArg1;  // RL6 RL7
            end else if (isCmd && (cmdCode == rmtr_pkg::CMD_REPEAT) &&
                         (cmdLen == rmtr_pkg::LEN_REPEAT) &&
                         argOk(cmdArg1) && argOk(cmdArg2)) begin
                repSelFf       <= cmdArg1;  // RL19 RL20
                repDepthFf     <= cmdArg2;  // RL21
                nvWrite        <= 1'b1;     // RL22
                nvRepSelectOut <= cmdArg1;
                nvRepDepthOut  <= cmdArg2;
            end
        end
    end

    // response generation
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rspValid      <= 1'b0;
            rspType       <= rmtr_pkg::PKT_RESPONSE;
            rspLen        <= rmtr_pkg::LEN_SHORT_RSP;
            rspReturn     <= rmtr_pkg::RET_SUCCESS;
            rspUsedPct    <= 8'h00;
            rspSlots      <= rmtr_pkg::SLOT_COUNT;
            rspSlotPeriod <= rmtr_pkg::SLOT_SECONDS;
            rspSlotLeft   <= rmtr_pkg::SLOT_SECONDS;
            rspNextPct    <= 8'h00;
        end else begin
            rspValid <= 1'b0;
            rspType  <= rmtr_pkg::PKT_RESPONSE;  // RL2
            rspLen   <= rmtr_pkg::LEN_SHORT_RSP;
            if (isCmd && (cmdCode == rmtr_pkg::CMD_DUTY_QRY) &&
                (cmdLen == rmtr_pkg::LEN_DUTY_QRY)) begin
                rspValid      <= 1'b1;  // RL1
                rspLen        <= rmtr_pkg::LEN_DUTY_RSP;  // RL2
                rspReturn     <= rmtr_pkg::RET_SUCCESS;
                rspUsedPct    <= (budgetUsedPct > rmtr_pkg::PCT_FULL) ?
                                 rmtr_pkg::PCT_FULL : budgetUsedPct;  // RL3
                rspSlots      <= rmtr_pkg::SLOT_COUNT;    // RL4
                rspSlotPeriod <= rmtr_pkg::SLOT_SECONDS;  // RL4
                rspSlotLeft   <= slotLeftFf;              // RL5
                rspNextPct    <= (budgetNextPct > rmtr_pkg::PCT_FULL) ?
                                 rmtr_pkg::PCT_FULL : budgetNextPct;  // RL5
            end else if (isCmd && (cmdCode == rmtr_pkg::CMD_TXONLY)) begin
                rspValid  <= 1'b1;
                rspReturn <= argOk(cmdArg1) ? rmtr_pkg::RET_SUCCESS
                                            : rmtr_pkg::RET_ERROR;  // RL25 RL26
            end else if (isCmd && (cmdCode == rmtr_pkg::CMD_REPEAT)) begin
                rspValid  <= 1'b1;
                rspReturn <= (argOk(cmdArg1) && argOk(cmdArg2)) ?
                             rmtr_pkg::RET_SUCCESS : rmtr_pkg::RET_ERROR;  // RL25 RL26
            end else if (txReq && budgetEmpty) begin
                rspValid  <= 1'b1;
                rspReturn <= rmtr_pkg::RET_LOCKED;  // RL24
            end
        end
    end

    // random delay source
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            lfsrFf <= 16'hACE1;
        else
            lfsrFf <= {lfsrFf[14:0], lfsrFf[15] ^ lfsrFf[13] ^ lfsrFf[12] ^ lfsrFf[10]};
    end

    // radio control state machine
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stateFf               <= rmtr_pkg::ST_RECEIVE;
            radioSend             <= 1'b0;
            sendingRepeatFf       <= 1'b0;
            repCntFf              <= 4'h0;
            delayFf               <= 8'h00;
            transmitCompleteEvent <= 1'b0;
            sleepDuration         <= rmtr_pkg::SLEEP_FOREVER;
        end else begin
            radioSend             <= 1'b0;
            transmitCompleteEvent <= 1'b0;
            case (stateFf)
                rmtr_pkg::ST_RECEIVE, rmtr_pkg::ST_IDLE: begin
                    if (txReq && !budgetEmpty) begin  // RL24
                        radioSend       <= 1'b1;  // RL10
                        sendingRepeatFf <= 1'b0;
                        stateFf         <= rmtr_pkg::ST_SEND;
                    end else if ((stateFf == rmtr_pkg::ST_RECEIVE) && repQualify) begin
                        repCntFf <= telRepCount + 4'h1;  // RL17
                        delayFf  <= lfsrFf[7:0];         // RL15 RL16
                        stateFf  <= rmtr_pkg::ST_REPWAIT;
                    end else if (modeFf != rmtr_pkg::MODE_RXTX) begin
                        stateFf <= rmtr_pkg::ST_IDLE;  // RL9
                    end else begin
                        stateFf <= rmtr_pkg::ST_RECEIVE;  // RL8
                    end
                end
                rmtr_pkg::ST_REPWAIT: begin
                    if (modeFf != rmtr_pkg::MODE_RXTX) begin
                        stateFf <= rmtr_pkg::ST_IDLE;  // RL13
                    end else if (delayFf == 8'h00) begin
                        if (!budgetEmpty) begin
                            radioSend       <= 1'b1;  // RL14
                            sendingRepeatFf <= 1'b1;
                            stateFf         <= rmtr_pkg::ST_SEND;
                        end else begin
                            stateFf <= rmtr_pkg::ST_RECEIVE;
                        end
                    end else begin
                        delayFf <= delayFf - 8'h01;
                    end
                end
                rmtr_pkg::ST_SEND: begin
                    if (radioDone) begin
                        transmitCompleteEvent <= !sendingRepeatFf;  // RL10
                        if (modeFf == rmtr_pkg::MODE_TXO_SLP) begin
                            sleepDuration <= rmtr_pkg::SLEEP_FOREVER;  // RL11
                            stateFf       <= rmtr_pkg::ST_SLEEP;
                        end else if (modeFf == rmtr_pkg::MODE_TXO) begin
                            stateFf <= rmtr_pkg::ST_IDLE;  // RL9
                        end else begin
                            stateFf <= rmtr_pkg::ST_RECEIVE;  // RL14
                        end
                    end
                end
                rmtr_pkg::ST_SLEEP: begin
                    if (cmdValid)
                        stateFf <= rmtr_pkg::ST_IDLE;  // RL12
                end
                default: stateFf <= rmtr_pkg::ST_RECEIVE;
            endcase
        end
    end

    assign receiverOn   = (stateFf == rmtr_pkg::ST_RECEIVE) ||
                          (stateFf == rmtr_pkg::ST_REPWAIT);  // RL8
    assign sleeping     = (stateFf == rmtr_pkg::ST_SLEEP);
    assign sendIsRepeat = sendingRepeatFf;
    assign repCountOut  = repCntFf;

    AST_DUTY_ANSWER: assert property (@(posedge mclk) disable iff (!reset_n)
        isCmd && cmdCode == rmtr_pkg::CMD_DUTY_QRY && cmdLen == rmtr_pkg::LEN_DUTY_QRY
        |=> rspValid && rspLen == 16'h0008 && rspReturn == 8'h00 && rspType == 8'h02) // RL1
        else $error("duty query not answered");
    AST_USED_LIMIT: assert property (@(posedge mclk) disable iff (!reset_n)
        rspValid && rspLen == rmtr_pkg::LEN_DUTY_RSP |-> rspUsedPct <= 8'h64
        && rspSlots == 8'h0A && rspSlotPeriod == 16'h0168) // RL3
        else $error("duty fields out of range");
    AST_IDLE_AFTER: assert property (@(posedge mclk) disable iff (!reset_n)
        stateFf == rmtr_pkg::ST_SEND && radioDone && modeFf == rmtr_pkg::MODE_TXO
        && !sendingRepeatFf
        |=> stateFf == rmtr_pkg::ST_IDLE && !receiverOn && transmitCompleteEvent) // RL9
        else $error("transmit-only did not go idle");
    AST_AUTO_SLEEP: assert property (@(posedge mclk) disable iff (!reset_n)
        stateFf == rmtr_pkg::ST_SEND && radioDone && modeFf == rmtr_pkg::MODE_TXO_SLP
        |=> sleeping && sleepDuration == 16'h0000) // RL11
        else $error("auto sleep not entered");
    AST_SLEEP_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        sleeping && !cmdValid |=> sleeping) // RL12
        else $error("woke without command");
    AST_NO_REPEAT_TXO: assert property (@(posedge mclk) disable iff (!reset_n)
        telValid && modeFf != rmtr_pkg::MODE_RXTX && !txReq
        |=> stateFf != rmtr_pkg::ST_REPWAIT && !radioSend) // RL13
        else $error("repeat while transmit-only");
    AST_REP_COUNT: assert property (@(posedge mclk) disable iff (!reset_n)
        stateFf == rmtr_pkg::ST_RECEIVE && repQualify && !txReq
        |=> stateFf == rmtr_pkg::ST_REPWAIT && repCntFf == $past(telRepCount) + 4'h1) // RL17
        else $error("repeat counter wrong");
    AST_LOCKED: assert property (@(posedge mclk) disable iff (!reset_n)
        txReq && budgetEmpty && !isCmd |=> rspValid && rspReturn == 8'h02 && !radioSend) // RL24
        else $error("locked request not refused");
    AST_BAD_ARG: assert property (@(posedge mclk) disable iff (!reset_n)
        nvLoadedFf && isCmd && cmdCode == rmtr_pkg::CMD_TXONLY && cmdArg1 > 8'h02
        |=> rspReturn == 8'h01 && modeFf == $past(modeFf)) // RL25
        else $error("bad mode accepted");
endmodule // rmtr_ctrl

// File: rtl/rmtr_pkg.sv
package rmtr_pkg;
    // packet identification
    localparam logic [7:0]  PKT_COMMAND   = 8'h05;  // general command packet
    localparam logic [7:0]  PKT_RESPONSE  = 8'h02;  // response packet
    localparam logic [7:0]  CMD_DUTY_QRY  = 8'h23;  // duty budget query
    localparam logic [7:0]  CMD_TXONLY    = 8'h40;  // transmit-only config
    localparam logic [7:0]  CMD_REPEAT    = 8'h09;  // repeater config
    localparam logic [15:0] LEN_DUTY_QRY  = 16'h0001;
    localparam logic [15:0] LEN_TXONLY    = 16'h0002;
    localparam logic [15:0] LEN_REPEAT    = 16'h0003;
    localparam logic [15:0] LEN_DUTY_RSP  = 16'h0008;
    localparam logic [15:0] LEN_SHORT_RSP = 16'h0001;
    // return codes
    localparam logic [7:0]  RET_SUCCESS   = 8'h00;
    localparam logic [7:0]  RET_ERROR     = 8'h01;
    localparam logic [7:0]  RET_LOCKED    = 8'h02;
    // mode and repeater encodings
    localparam logic [7:0]  MODE_RXTX     = 8'h00;
    localparam logic [7:0]  MODE_TXO      = 8'h01;
    localparam logic [7:0]  MODE_TXO_SLP  = 8'h02;
    localparam logic [7:0]  REP_OFF       = 8'h00;
    localparam logic [7:0]  REP_ALL       = 8'h01;
    localparam logic [7:0]  REP_SELECT    = 8'h02;
    localparam logic [7:0]  DEPTH_ONE     = 8'h01;
    localparam logic [7:0]  DEPTH_TWO     = 8'h02;
    localparam logic [7:0]  ARG_MAX       = 8'h02;
    localparam logic [7:0]  PCT_FULL      = 8'h64;  // 100 percent
    localparam logic [15:0] SLEEP_FOREVER = 16'h0000;
    // duty budget slots
    localparam logic [7:0]  SLOT_COUNT    = 8'h0A;  // 10 slots
    localparam logic [15:0] SLOT_SECONDS  = 16'h0168; // 360 s
    localparam int          CLK_HZ        = 40000000;
    localparam logic [3:0]  REP_CNT_ONE   = 4'h1;
    // radio control states
    typedef enum logic [2:0] {
        ST_RECEIVE = 3'b000,
        ST_SEND    = 3'b001,
        ST_IDLE    = 3'b010,
        ST_SLEEP   = 3'b011,
        ST_REPWAIT = 3'b100
    } rmtr_state_type;
endpackage

// File: dv/rmtr_radio_model.sv
`timescale 1ns/1ps
// radio side: finishes each send after a chosen number of cycles
module rmtr_radio_model (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       radioSend,   // start pulse from the block
    input  wire logic [3:0] radioDelay,  // extra cycles, 0 is prompt
    output logic            radioDone    // one-cycle finish pulse
);
    int cnt;  // cycles until the send finishes

    // countdown per send, driven off the sampling edge
    always @(negedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            radioDone <= 1'b0;
            cnt = 0;
        end else begin
            radioDone <= (cnt == 1);
            if (cnt > 0) cnt--;
            if (radioSend === 1'b1) cnt = radioDelay + 2;
        end
    end
endmodule // rmtr_radio_model

// File: dv/testbench.sv
`timescale 1ns/1ps
// bench: drives host packets, telegrams and budget levels against a model
module testbench;
    logic        mclk = 1'b0, reset_n = 1'b0, cmdValid = 1'b0, txReq = 1'b0, budgetEmpty = 1'b0;
    logic        telValid = 1'b0, telFilterHit = 1'b0, radioDone, rspValid, radioSend;
    logic        sendIsRepeat, receiverOn, sleeping, transmitCompleteEvent, nvWrite, slotTick;
    int          slotCyc = 0, ticks = 0;  // cycles since reset release, slot pulses seen
    logic [7:0]  cmdType = 8'h00, cmdCode = 8'h00, cmdArg1 = 8'h00, cmdArg2 = 8'h00;
    logic [7:0]  budgetUsedPct = 8'h00, budgetNextPct = 8'h00, nvSel = 8'h00, nvDep = 8'h00;
    logic [7:0]  rspType, rspReturn, rspUsedPct, rspSlots, rspNextPct, nvRepSelectOut, nvRepDepthOut;
    logic [15:0] cmdLen = 16'h0000, rspLen, rspSlotPeriod, rspSlotLeft, sleepDuration;
    logic [3:0]  telRepCount = 4'h0, repCountOut, radioDelay = 4'h0;
    int          errors = 0, num_checks = 0, cycles = 0, mode = 0, rsel = 0, rdep = 0;
    int          order[4] = '{1, 2, 3, 0};  // mode bytes tried, normal last
    bit          got;

    always #12.5 mclk = ~mclk;  // 40 MHz

    rmtr_ctrl #(.SEC_CYCLES(4)) rmtr_ctrl_inst (
        .mclk, .reset_n, .cmdValid, .cmdType, .cmdLen, .cmdCode, .cmdArg1, .cmdArg2, .txReq,
        .budgetUsedPct, .budgetNextPct, .budgetEmpty, .radioDone, .telValid, .telRepCount,
        .telFilterHit, .nvRepSelect(nvSel), .nvRepDepth(nvDep), .rspValid, .rspType, .rspLen,
        .rspReturn, .rspUsedPct, .rspSlots, .rspSlotPeriod, .rspSlotLeft, .rspNextPct,
        .radioSend, .sendIsRepeat, .repCountOut, .receiverOn, .sleeping, .sleepDuration,
        .transmitCompleteEvent, .slotTick, .nvWrite, .nvRepSelectOut, .nvRepDepthOut
    );
    rmtr_radio_model rmtr_radio_model_inst (
        .mclk, .reset_n, .radioSend, .radioDelay, .radioDone
    );

    // non-volatile store, survives resets
    always @(posedge mclk) begin
        if (nvWrite === 1'b1) begin
            nvSel <= nvRepSelectOut;
            nvDep <= nvRepDepthOut;
        end
    end

    // slot boundary every 360 seconds of 4 cycles, pulse seen one edge later
    always @(posedge mclk) begin
        if (reset_n !== 1'b1) slotCyc = 0;
        else slotCyc++;
        if (slotTick === 1'b1) begin
            ticks++;
            chk("slot tick", 16'(slotCyc % (rmtr_pkg::SLOT_SECONDS * 4)), 16'h0001);
        end
    end

    // watchdog against hangs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // poll a one-cycle output at falling edges: 0 answer, 1 send, 2 complete
    task automatic waitFor(input int which, input int lim, output bit seen);
        seen = 0;
        for (int i = 0; i < lim && !seen; i++) begin
            if ((which == 0 ? rspValid : which == 1 ? radioSend : transmitCompleteEvent) === 1'b1)
                seen = 1;
            else
                @(negedge mclk);
        end
    endtask

    task automatic cmd(input logic [7:0] code, input logic [15:0] len, input logic [7:0] a1, a2);
        @(negedge mclk);
        {cmdValid, cmdType, cmdLen} = {1'b1, rmtr_pkg::PKT_COMMAND, len};
        {cmdCode, cmdArg1, cmdArg2} = {code, a1, a2};
        @(negedge mclk);
        cmdValid = 1'b0;
        waitFor(0, 3, got);
    endtask

    // configuration command, model updated only when accepted
    task automatic cfg(input logic [7:0] code, input int a1, a2);
        logic [7:0] ret;
        ret = (a1 > 2 || a2 > 2) ? rmtr_pkg::RET_ERROR : rmtr_pkg::RET_SUCCESS;
        cmd(code, (code == rmtr_pkg::CMD_TXONLY) ? 16'h0002 : 16'h0003, a1[7:0], a2[7:0]);
        chk("cfg answer", got, 1'b1);
        chk("cfg return", rspReturn, ret);
        if (ret == 8'h00 && code == rmtr_pkg::CMD_TXONLY) mode = a1;
        if (ret == 8'h00 && code == rmtr_pkg::CMD_REPEAT) begin
            rsel = a1;
            rdep = a2;
        end
    endtask

    // received telegram, repeat expected from the model
    task automatic tel(input int cnt, input bit hit);
        bit seen, exp;
        exp = mode == 0 && (rsel == 1 || (rsel == 2 && hit)) &&
              ((rdep == 1 && cnt == 0) || (rdep == 2 && cnt <= 1));
        radioDelay = 4'($urandom % 16);
        @(negedge mclk);
        {telValid, telRepCount, telFilterHit} = {1'b1, 4'(cnt), hit};
        @(negedge mclk);
        telValid = 1'b0;
        waitFor(1, 270, seen);
        chk("repeat sent", seen, exp);
        if (seen) begin
            chk("repeat flag", sendIsRepeat, 1'b1);
            chk("repeat count", repCountOut, 4'(cnt + 1));
        end
        waitFor(2, 25, seen);
        chk("no complete on repeat", seen, 1'b0);
        if (mode == 0) chk("back to receive", receiverOn, 1'b1);
    endtask

    task automatic hostSend();
        @(negedge mclk);
        txReq = 1'b1;
        @(negedge mclk);
        txReq = 1'b0;
    endtask

    initial begin
        void'($urandom(32'h7372));
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        chk("receive at rest", receiverOn, 1'b1);
        budgetUsedPct = 8'($urandom % 101);
        budgetNextPct = 8'($urandom % 101);
        cmd(rmtr_pkg::CMD_DUTY_QRY, 16'h0001, 8'h00, 8'h00);
        chk("duty answer", got, 1'b1);
        chk("duty type", rspType, 8'h02);
        chk("duty length", rspLen, 16'h0008);
        chk("duty return", rspReturn, 8'h00);
        chk("used load", rspUsedPct, budgetUsedPct);
        chk("slot count", rspSlots, 8'h0A);
        chk("slot period", rspSlotPeriod, 16'h0168);
        chk("slot left", rspSlotLeft inside {[16'h0001:16'h0168]}, 1'b1);
        chk("next load", rspNextPct, budgetNextPct);
        cmd(rmtr_pkg::CMD_DUTY_QRY, 16'h0002, 8'h00, 8'h00);
        chk("bad length ignored", got, 1'b0);
        $display("test duty query done");
        foreach (order[k]) begin
            cfg(rmtr_pkg::CMD_TXONLY, order[k], 0);
            radioDelay = 4'($urandom % 16);
            hostSend();
            waitFor(1, 4, got);
            chk("send started", got, 1'b1);
            @(negedge mclk);
            waitFor(2, 30, got);
            chk("complete event", got, 1'b1);
            @(negedge mclk);
            chk("receiver after send", receiverOn, mode == 0);
            chk("asleep after send", sleeping, mode == 2);
            if (mode == 2) begin
                chk("sleep length", sleepDuration, 16'h0000);
                repeat (5) @(negedge mclk);
                chk("still asleep", sleeping, 1'b1);
                cmd(rmtr_pkg::CMD_DUTY_QRY, 16'h0001, 8'h00, 8'h00);
                chk("woken", sleeping, 1'b0);
            end
        end
        $display("test modes done");
        budgetEmpty = 1'b1;
        hostSend();
        waitFor(0, 3, got);
        chk("lock answer", got, 1'b1);
        chk("lock code", rspReturn, rmtr_pkg::RET_LOCKED);
        waitFor(1, 10, got);
        chk("no send when locked", got, 1'b0);
        budgetEmpty = 1'b0;
        $display("test budget lock done");
        for (int s = 0; s < 3; s++) begin
            for (int d = 0; d < 3; d++) begin
                cfg(rmtr_pkg::CMD_REPEAT, s, d);
                for (int c = 0; c < 6; c++) tel(c % 3, c / 3);
            end
        end
        cfg(rmtr_pkg::CMD_REPEAT, 1, 2);
        cfg(rmtr_pkg::CMD_REPEAT, 3, 1);
        tel(1, 1'b0);
        cfg(rmtr_pkg::CMD_TXONLY, 1, 0);
        tel(0, 1'b1);
        cfg(rmtr_pkg::CMD_TXONLY, 0, 0);
        $display("test repeater done");
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (3) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        tel(1, 1'b0);
        $display("test stored setting done");
        chk("slot ticks seen", ticks > 0, 1'b1);
        stop_test();
    end
endmodule // testbench
